// *** rtl/motor_pwm_unit.sv ***
// PWM time base with prescaler, postscaler, period buffering and duty registers.
`timescale 1ns/1ps
`default_nettype none
`include "motor_pwm_consts.svh"

module motor_pwm_unit
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic [3:0] pwm_o,
  output logic tb_event_o,
  output logic dir_o
);
  import motor_pwm_pkg::*;

  // Register map, one 16-bit word per index:
  //   0  control: enable in bit 15, postscale in 7:4, prescale in 3:2, mode in 1:0.
  //   1  count: direction flag in bit 15, count value in 14:0.
  //   2  period: 15-bit value in 14:0; bit 15 always reads back as zero.
  //   3  duty one, 4 duty two, 5 duty three, 6 duty four, all 16 bits wide.
  // Indices 7 and up are unmapped: writes are dropped and reads return zero.
  // Bus timing: a write lands on the strobe edge, and read data stand for
  // exactly the one cycle after the read strobe, then fall back to zero.
  // The slave never stalls, so strobes may follow each other with no gap.

  motor_pwm_pkg::tb_state_s s_r;
  motor_pwm_pkg::tb_state_s s_nxt;
  pwm_compare_if cif ();

  // Combinational helpers derived from the registered state and the bus write strobe.
  logic [5:0] presc_lim;
  logic tick;
  logic half_phase;
  logic period_match;
  logic raw_event;
  logic direct_event;
  logic wr_ctl;
  logic wr_cnt;

  // Prescale limit per selection code. The prescaler counts from zero up to
  // the limit, so a limit of three gives one counter tick in four clocks.
  // Codes are decoded from the registered field, so a new ratio takes hold
  // on the clock after the control write that cleared the prescaler.
  always_comb
  begin
    case (s_r.ckps)
      PRESC_DIV4: presc_lim = `MPWM_PRESC_LIM_4;
      PRESC_DIV16: presc_lim = `MPWM_PRESC_LIM_16;
      PRESC_DIV64: presc_lim = `MPWM_PRESC_LIM_64;
      default: presc_lim = `MPWM_PRESC_LIM_1;
    endcase
  end

  // Most significant prescaler bit gives the half-period phase for duty bit 0.
  // It is low in the first half of each tick and high in the second half,
  // which is what lets an odd duty value land its edge half a tick later.
  // At 1:1 there is no second half, so the phase reads as a constant zero.
  always_comb
  begin
    case (s_r.ckps)
      PRESC_DIV4: half_phase = s_r.presc[1];
      PRESC_DIV16: half_phase = s_r.presc[3];
      PRESC_DIV64: half_phase = s_r.presc[5];
      default: half_phase = 1'b0;
    endcase
  end

  // Input clock edge of the counter and the period comparison.
  // The comparison uses the hidden working period, never the visible one,
  // so a period write in mid-cycle cannot cut the running cycle short.
  assign tick = (s_r.presc == presc_lim);
  assign period_match = (s_r.count == s_r.per_work);
  // Write decodes for the two registers whose writes clear the scalers.
  assign wr_ctl = wr_i && (addr_i == `MPWM_OFS_CONTROL);
  assign wr_cnt = wr_i && (addr_i == `MPWM_OFS_COUNT);

  // Next-state logic: counting first, then software writes, which override.
  // The write branch comes last on purpose: a control write that sets the
  // enable in the same clock as a single-event halt leaves the time base
  // running, and a count write replaces the next count that the counter would load.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tb_event = 1'b0;
    s_nxt.rdata = `MPWM_RST_WORD;
    raw_event = 1'b0;
    direct_event = 1'b0;

    // Free-running prescaler counter.
    // It runs even while the time base is disabled; it only matters for the
    // tick and the half phase, and both are ignored until enable is set.
    if (tick)
      s_nxt.presc = '0;
    else
      s_nxt.presc = s_r.presc + 6'h01;

    // While stopped, the working period follows the visible one a clock later.
    // It trails the visible register by one clock, which is harmless since
    // nothing counts while the enable is clear.
    if (!s_r.en)
      s_nxt.per_work = s_r.period;

    // Counter advance, only on a prescaled edge while enabled.
    // Clearing the enable freezes count and direction where they stand, so a
    // later enable resumes from the same place rather than from zero.
    if (s_r.en && tick)
    begin
      case (s_r.mode)
        MODE_SINGLE:
        begin
          // Single event counts upward only, even after an up/down run.
          s_nxt.dir = 1'b0;
          if (period_match)
          begin
            s_nxt.count = `MPWM_RST_CNT;
            s_nxt.en = 1'b0;
            s_nxt.per_work = s_r.period;
            direct_event = 1'b1;
          end
          else
            s_nxt.count = s_r.count + 15'h0001;
        end
        // Up/down: one cycle covers twice the period in ticks. A period of
        // zero is not useful here: the turn at the top would step the count
        // below zero and wrap it, so software must keep the period nonzero.
        MODE_UPDOWN, MODE_DOUBLE:
        begin
          if (!s_r.dir)
          begin
            if (s_r.count == `MPWM_RST_CNT)
              s_nxt.per_work = s_r.period;
            if (period_match)
            begin
              // Reverse on this edge; the count starts down from here.
              s_nxt.dir = 1'b1;
              s_nxt.count = s_r.count - 15'h0001;
              if (s_r.mode == MODE_DOUBLE)
                direct_event = 1'b1;
            end
            else
              s_nxt.count = s_r.count + 15'h0001;
          end
          else
          begin
            if (s_r.count == `MPWM_RST_CNT)
            begin
              // Bottom reached: turn upward and reload the period.
              s_nxt.dir = 1'b0;
              s_nxt.count = 15'h0001;
              s_nxt.per_work = s_r.period;
              if (s_r.mode == MODE_DOUBLE)
                direct_event = 1'b1;
              else
                raw_event = 1'b1;
            end
            else
              s_nxt.count = s_r.count - 15'h0001;
          end
        end
        default:
        begin
          // Free running counts upward only, even after an up/down run.
          s_nxt.dir = 1'b0;
          if (period_match)
          begin
            s_nxt.count = `MPWM_RST_CNT;
            s_nxt.per_work = s_r.period;
            raw_event = 1'b1;
          end
          else
            s_nxt.count = s_r.count + 15'h0001;
        end
      endcase
    end

    // Postscaler passes one raw event in ops+1; direct events bypass it.
    // The compare is against the registered ratio, so lowering the ratio
    // below the running postscaler count would skip a long way; the control
    // write that changes it also clears that count, which avoids the skip.
    if (raw_event)
    begin
      if (s_r.post == s_r.ops)
      begin
        s_nxt.post = `MPWM_RST_POST;
        s_nxt.tb_event = 1'b1;
      end
      else
        s_nxt.post = s_r.post + 4'h1;
    end
    if (direct_event)
      s_nxt.tb_event = 1'b1;

    // Register writes; a control write restarts both scalers but not the count.
    // Only bits 14:0 of count and period are stored; the direction flag is
    // owned by the counter and cannot be set from the bus.
    if (wr_i)
    begin
      if (addr_i == `MPWM_OFS_CONTROL)
      begin
        s_nxt.en = wdata_i[`MPWM_CTL_EN_BIT];
        s_nxt.ops = wdata_i[`MPWM_CTL_OPS_HI:`MPWM_CTL_OPS_LO];
        s_nxt.ckps = presc_e'(wdata_i[`MPWM_CTL_CKPS_HI:`MPWM_CTL_CKPS_LO]);
        s_nxt.mode = mode_e'(wdata_i[`MPWM_CTL_MODE_HI:`MPWM_CTL_MODE_LO]);
      end
      else if (addr_i == `MPWM_OFS_COUNT)
      begin
        s_nxt.count = wdata_i[14:0];
      end
      else if (addr_i == `MPWM_OFS_PERIOD)
      begin
        s_nxt.period = wdata_i[14:0];
      end
      else if (addr_i == `MPWM_OFS_DUTY_ONE)
      begin
        s_nxt.duty[0] = wdata_i;
      end
      else if (addr_i == `MPWM_OFS_DUTY_TWO)
      begin
        s_nxt.duty[1] = wdata_i;
      end
      else if (addr_i == `MPWM_OFS_DUTY_THREE)
      begin
        s_nxt.duty[2] = wdata_i;
      end
      else if (addr_i == `MPWM_OFS_DUTY_FOUR)
      begin
        s_nxt.duty[3] = wdata_i;
      end
    end
    if (wr_ctl || wr_cnt)
    begin
      s_nxt.presc = '0;
      s_nxt.post = `MPWM_RST_POST;
    end

    // Read data stand in the cycle after the strobe; unmapped reads return zero.
    // Reads have no side effects, so a read may be repeated freely.
    if (rd_i)
    begin
      if (addr_i == `MPWM_OFS_CONTROL)
      begin
        s_nxt.rdata[`MPWM_CTL_EN_BIT] = s_r.en;
        s_nxt.rdata[`MPWM_CTL_OPS_HI:`MPWM_CTL_OPS_LO] = s_r.ops;
        s_nxt.rdata[`MPWM_CTL_CKPS_HI:`MPWM_CTL_CKPS_LO] = s_r.ckps;
        s_nxt.rdata[`MPWM_CTL_MODE_HI:`MPWM_CTL_MODE_LO] = s_r.mode;
      end
      else if (addr_i == `MPWM_OFS_COUNT)
      begin
        s_nxt.rdata = {s_r.dir, s_r.count};
      end
      else if (addr_i == `MPWM_OFS_PERIOD)
      begin
        s_nxt.rdata = {1'b0, s_r.period};
      end
      else if (addr_i == `MPWM_OFS_DUTY_ONE)
      begin
        s_nxt.rdata = s_r.duty[0];
      end
      else if (addr_i == `MPWM_OFS_DUTY_TWO)
      begin
        s_nxt.rdata = s_r.duty[1];
      end
      else if (addr_i == `MPWM_OFS_DUTY_THREE)
      begin
        s_nxt.rdata = s_r.duty[2];
      end
      else if (addr_i == `MPWM_OFS_DUTY_FOUR)
      begin
        s_nxt.rdata = s_r.duty[3];
      end
    end
  end

  // State register; the synchronous reset also clears both scalers.
  // Reset leaves the time base disabled in free running mode at 1:1 with
  // every register at zero, so all outputs start low.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Feed the compare unit from registered state only.
  // Registered inputs keep the compare paths short, at the price of the
  // outputs trailing the count by one clock.
  assign cif.count = s_r.count;
  assign cif.dir = s_r.dir;
  assign cif.mode = s_r.mode;
  assign cif.enable = s_r.en;
  assign cif.fine = (s_r.ckps == PRESC_DIV1);
  assign cif.half_phase = half_phase;
  assign cif.duty = s_r.duty;

  // Duty compare generators; their outputs are flip-flops.
  // The compare unit shares the clock and reset, so the whole block stays
  // in one clock domain.
  pwm_duty_compare u_cmp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cif(cif)
  );

  // Outputs come straight from flip-flops.
  // The direction output mirrors the flag that the count register reads
  // back in bit 15, so both always agree.
  assign rdata_o = s_r.rdata;
  assign tb_event_o = s_r.tb_event;
  assign dir_o = s_r.dir;
  assign pwm_o = cif.pwm;
endmodule
`default_nettype wire

// *** rtl/motor_pwm_consts.svh ***
// Register offsets, field positions, reset values and prescale counts of the PWM time base.
`ifndef MOTOR_PWM_CONSTS_SVH
`define MOTOR_PWM_CONSTS_SVH

`define MPWM_ADDR_W 4
`define MPWM_DATA_W 16
`define MPWM_CNT_W 15
`define MPWM_NUM_GEN 4

`define MPWM_OFS_CONTROL 4'h0
`define MPWM_OFS_COUNT 4'h1
`define MPWM_OFS_PERIOD 4'h2
`define MPWM_OFS_DUTY_ONE 4'h3
`define MPWM_OFS_DUTY_TWO 4'h4
`define MPWM_OFS_DUTY_THREE 4'h5
`define MPWM_OFS_DUTY_FOUR 4'h6

`define MPWM_CTL_EN_BIT 15
`define MPWM_CTL_OPS_HI 7
`define MPWM_CTL_OPS_LO 4
`define MPWM_CTL_CKPS_HI 3
`define MPWM_CTL_CKPS_LO 2
`define MPWM_CTL_MODE_HI 1
`define MPWM_CTL_MODE_LO 0
`define MPWM_CNT_DIR_BIT 15

`define MPWM_PRESC_W 6
`define MPWM_PRESC_LIM_1 6'h00
`define MPWM_PRESC_LIM_4 6'h03
`define MPWM_PRESC_LIM_16 6'h0f
`define MPWM_PRESC_LIM_64 6'h3f

`define MPWM_RST_WORD 16'h0000
`define MPWM_RST_CNT 15'h0000
`define MPWM_RST_POST 4'h0

`endif

// *** rtl/motor_pwm_pkg.sv ***
// Types shared by the PWM time base and its duty compare unit.
package motor_pwm_pkg;

  // Time base operating mode, encoded as the two-bit control field.
  typedef enum logic [1:0] {
    MODE_FREE = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_UPDOWN = 2'h2,
    MODE_DOUBLE = 2'h3
  } mode_e;

  // Input prescale selection.
  typedef enum logic [1:0] {
    PRESC_DIV1 = 2'h0,
    PRESC_DIV4 = 2'h1,
    PRESC_DIV16 = 2'h2,
    PRESC_DIV64 = 2'h3
  } presc_e;

  // Whole state of the time base and register file.
  typedef struct packed {
    logic en;
    logic [3:0] ops;
    presc_e ckps;
    mode_e mode;
    logic [14:0] count;
    logic dir;
    logic [14:0] period;
    logic [14:0] per_work;
    logic [3:0][15:0] duty;
    logic [5:0] presc;
    logic [3:0] post;
    logic tb_event;
    logic [15:0] rdata;
  } tb_state_s;

  // Whole state of the duty compare unit.
  typedef struct packed {
    logic [3:0] pwm;
  } cmp_state_s;

endpackage

// *** rtl/pwm_compare_if.sv ***
// Signals passed from the time base to the duty compare unit.
`timescale 1ns/1ps
`default_nettype none
interface pwm_compare_if;
  import motor_pwm_pkg::*;
  logic [14:0] count;
  logic dir;
  mode_e mode;
  logic enable;
  logic fine;
  logic half_phase;
  logic [3:0][15:0] duty;
  logic [3:0] pwm;

  modport base (output count, dir, mode, enable, fine, half_phase, duty, input pwm);
  modport cmp (input count, dir, mode, enable, fine, half_phase, duty, output pwm);
endinterface
`default_nettype wire

// *** rtl/pwm_duty_compare.sv ***
// Four duty compare generators driving the PWM outputs.
`timescale 1ns/1ps
`default_nettype none
module pwm_duty_compare
(
  input wire logic clk_i,
  input wire logic rst_i,
  pwm_compare_if.cmp cif
);
  import motor_pwm_pkg::*;

  cmp_state_s s_r;
  cmp_state_s s_nxt;
  logic [3:0] match;

  // Duty bits 15:1 meet the count; bit 0 picks the prescaler half phase.
  // At 1:1 a single clock cannot place a half-cycle edge, so bit 0 is
  // taken as met and the edge lands on the whole cycle.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gen_match
      assign match[g] = (cif.count == cif.duty[g][15:1]) &&
                        (cif.fine || (cif.half_phase == cif.duty[g][0]));
    end
  endgenerate

  // Set and clear of each output; a clear on the same cycle wins, and the set
  // skips a duty of zero, so that duty gives no pulse at all.
  always_comb
  begin
    s_nxt = s_r;
    for (int i = 0; i < 4; i++)
    begin
      if (cif.mode == MODE_FREE || cif.mode == MODE_SINGLE)
      begin
        if (!cif.enable)
        begin
          if (cif.mode == MODE_SINGLE)
            s_nxt.pwm[i] = 1'b0;
        end
        else
        begin
          if (cif.count == 15'h0000 && cif.duty[i] != 16'h0000)
            s_nxt.pwm[i] = 1'b1;
          if (match[i])
            s_nxt.pwm[i] = 1'b0;
        end
      end
      else if (cif.enable && cif.duty[i] == 16'h0000)
      begin
        // A zero duty matches only at the bottom turn, which would latch the
        // output on; it is kept off for the whole period instead.
        s_nxt.pwm[i] = 1'b0;
      end
      else if (cif.enable && match[i])
      begin
        s_nxt.pwm[i] = cif.dir;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign cif.pwm = s_r.pwm;
endmodule
`default_nettype wire

// *** verification/motor_pwm_unit_asserts.sv ***
// Checker of register readback and count direction of the PWM time base.
`timescale 1ns/1ps
`default_nettype none
`include "motor_pwm_consts.svh"
module motor_pwm_unit_asserts
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [3:0] pwm_o,
  input wire logic tb_event_o,
  input wire logic dir_o
);
  logic [15:0] ctl_r;
  logic [14:0] per_r;
  logic [3:0][15:0] duty_r;
  logic [3:0] di;
  logic [15:0] duty_sel;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Index of the duty register that the bus addresses.
  assign di = addr_i - `MPWM_OFS_DUTY_ONE;
  assign duty_sel = duty_r[di[1:0]];
  // Shadows of what software wrote; the hardware enable clear is not tracked.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_r <= 16'h0000;
      per_r <= 15'h0000;
      duty_r <= '0;
    end
    else if (wr_i)
    begin
      if (addr_i == `MPWM_OFS_CONTROL) ctl_r <= wdata_i;
      if (addr_i == `MPWM_OFS_PERIOD) per_r <= wdata_i[14:0];
      if (di < 4'h4) duty_r[di[1:0]] <= wdata_i;
    end
  end
  dir_read_a: assert property (rd_i && addr_i == `MPWM_OFS_COUNT
    |=> rdata_o[15] == $past(dir_o))
    else $error("count read lost direction");
  mode_read_a: assert property (rd_i && addr_i == `MPWM_OFS_CONTROL
    |=> rdata_o[1:0] == $past(ctl_r[1:0]))
    else $error("mode field readback wrong");
  presc_read_a: assert property (rd_i && addr_i == `MPWM_OFS_CONTROL
    |=> rdata_o[3:2] == $past(ctl_r[3:2]))
    else $error("prescale field readback wrong");
  post_read_a: assert property (rd_i && addr_i == `MPWM_OFS_CONTROL
    |=> rdata_o[7:4] == $past(ctl_r[7:4]))
    else $error("postscale field readback wrong");
  per_read_a: assert property (rd_i && addr_i == `MPWM_OFS_PERIOD
    |=> rdata_o == {1'b0, $past(per_r)})
    else $error("period readback wrong");
  duty_read_a: assert property (rd_i && di < 4'h4 |=> rdata_o == $past(duty_sel))
    else $error("duty readback wrong");
  dir_hold_a: assert property (!ctl_r[15] && !wr_i |=> $stable(dir_o))
    else $error("direction moved while disabled");
  dir_rise_a: assert property ($rose(dir_o) |-> ctl_r[1] || $past(ctl_r[1]))
    else $error("down count outside up/down modes");
  cover property (tb_event_o);
  cover property ($rose(dir_o));
  cover property ($rose(pwm_o[0]));
endmodule
`default_nettype wire

// *** verification/pwm_driver_model.sv ***
// Gate driver model: counts the cycles that each output holds its transistor on.
`timescale 1ns/1ps
`default_nettype none
module pwm_driver_model
(
  input wire logic clk_i,
  input wire logic clear_i,
  input wire logic [3:0] pwm_i,
  output logic [3:0][7:0] on_cnt_o
);
  // Counters wrap at 256, so measuring windows must stay shorter.
  always_ff @(posedge clk_i)
  begin
    for (int g = 0; g < 4; g++)
    begin
      if (clear_i) on_cnt_o[g] <= 8'h00;
      else if (pwm_i[g]) on_cnt_o[g] <= on_cnt_o[g] + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** verification/motor_pwm_unit_tb.sv ***
// Self-checking bench of the PWM time base and duty compare.
`timescale 1ns/1ps
`default_nettype none
`include "motor_pwm_consts.svh"
module motor_pwm_unit_tb;
  localparam logic [3:0] ctl_a = `MPWM_OFS_CONTROL;
  localparam logic [3:0] cnt_a = `MPWM_OFS_COUNT;
  localparam logic [3:0] per_a = `MPWM_OFS_PERIOD;
  logic clk_i, rst_i, wr_i, rd_i, clr, seen_dir, tb_event_o, dir_o;
  logic [3:0] addr_i, pwm_o;
  logic [15:0] wdata_i, rv, rdata_o;
  logic [3:0][7:0] on_cnt;
  int mismatches, tests_run, n;
  motor_pwm_unit motor_pwm_unit_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pwm_o(pwm_o),
    .tb_event_o(tb_event_o), .dir_o(dir_o));
  pwm_driver_model pwm_driver_model_i (.clk_i(clk_i), .clear_i(clr), .pwm_i(pwm_o),
    .on_cnt_o(on_cnt));
  // Free-running 100 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Cycles over k event intervals; bounded so a silent time base cannot hang the run.
  task automatic gap(input int k, output int c);
    c = 0;
    // Skip the event that the writing edge may launch under the old settings.
    @(negedge clk_i);
    for (int i = 0; i < 300; i++)
    begin
      @(negedge clk_i);
      if (tb_event_o === 1'b1) break;
    end
    for (int e = 0; e < k && c < 300; c++)
    begin
      @(negedge clk_i);
      seen_dir = seen_dir | dir_o;
      if (tb_event_o === 1'b1) e++;
    end
  endtask
  // Stops the time base and sets count and period for the next scenario.
  task automatic prep(input logic [15:0] p);
    wr(ctl_a, 16'h0000);
    wr(cnt_a, 16'h0000);
    wr(per_a, p);
    seen_dir = 1'b0;
  endtask
  task automatic meas(input int w);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (w) @(posedge clk_i);
    #1;
  endtask
  task automatic t_regs;
    for (int a = 0; a < 8; a++)
    begin
      rd(4'(a), rv);
      chk(rv, 16'h0000);
    end
    wr(per_a, 16'hffff);
    rd(per_a, rv);
    chk(rv, 16'h7fff);
    wr(cnt_a, 16'h8007);
    repeat (20) @(posedge clk_i);
    rd(cnt_a, rv);
    chk(rv, 16'h0007);
    wr(`MPWM_OFS_DUTY_FOUR, 16'ha5c3);
    rd(`MPWM_OFS_DUTY_FOUR, rv);
    chk(rv, 16'ha5c3);
    wr(4'h7, 16'h1234);
    rd(4'h7, rv);
    chk(rv, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_free;
    prep(16'h0002);
    wr(ctl_a, 16'h8000);
    gap(2, n);
    chk(16'(n), 16'h0006);
    wr(ctl_a, 16'h8010);
    gap(1, n);
    chk(16'(n), 16'h0006);
    wr(ctl_a, 16'h80f0);
    gap(1, n);
    chk(16'(n), 16'h0030);
    wr(ctl_a, 16'h8004);
    gap(1, n);
    chk(16'(n), 16'h000c);
    wr(ctl_a, 16'h800c);
    gap(1, n);
    chk(16'(n), 16'h00c0);
    chk({15'h0000, seen_dir}, 16'h0000);
    $display("test free done");
  endtask
  task automatic t_single;
    prep(16'h0003);
    wr(ctl_a, 16'h8031);
    gap(0, n);
    chk({15'h0000, tb_event_o}, 16'h0001);
    rd(ctl_a, rv);
    chk(rv, 16'h0031);
    rd(cnt_a, rv);
    chk(rv, 16'h0000);
    $display("test single done");
  endtask
  task automatic t_updown;
    prep(16'h0003);
    wr(ctl_a, 16'h8002);
    gap(1, n);
    chk(16'(n), 16'h0006);
    chk({15'h0000, seen_dir}, 16'h0001);
    wr(ctl_a, 16'h8013);
    gap(2, n);
    chk(16'(n), 16'h0006);
    $display("test updown done");
  endtask
  task automatic t_pwm;
    prep(16'h0009);
    wr(`MPWM_OFS_DUTY_ONE, 16'h0008);
    wr(`MPWM_OFS_DUTY_TWO, 16'h0000);
    wr(`MPWM_OFS_DUTY_THREE, 16'h0020);
    wr(`MPWM_OFS_DUTY_FOUR, 16'h000c);
    wr(ctl_a, 16'h8000);
    repeat (20) @(posedge clk_i);
    meas(50);
    chk({8'h00, on_cnt[0]}, 16'h0014);
    chk({8'h00, on_cnt[1]}, 16'h0000);
    chk({8'h00, on_cnt[2]}, 16'h0032);
    chk({8'h00, on_cnt[3]}, 16'h001e);
    prep(16'h0004);
    wr(`MPWM_OFS_DUTY_ONE, 16'h0004);
    wr(ctl_a, 16'h8002);
    repeat (24) @(posedge clk_i);
    meas(48);
    chk({8'h00, on_cnt[0]}, 16'h0018);
    chk({8'h00, on_cnt[1]}, 16'h0000);
    prep(16'h0003);
    wr(`MPWM_OFS_DUTY_ONE, 16'h0003);
    wr(`MPWM_OFS_DUTY_TWO, 16'h0002);
    wr(ctl_a, 16'h8004);
    repeat (20) @(posedge clk_i);
    meas(64);
    chk({8'h00, on_cnt[0]}, 16'h0018);
    chk({8'h00, on_cnt[1]}, 16'h0010);
    $display("test pwm done");
  endtask
  task automatic stop_test;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence after a four-cycle reset.
  initial
  begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    clr = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    seen_dir = 1'b0;
    mismatches = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_free;
    t_single;
    t_updown;
    t_pwm;
    stop_test;
  end
  // Watchdog well beyond the thousand or so cycles the scenarios need.
  initial
  begin
    #100000;
    mismatches++;
    stop_test;
  end
endmodule
bind motor_pwm_unit motor_pwm_unit_asserts motor_pwm_unit_asserts_i (.clk_i(clk_i),
  .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .pwm_o(pwm_o), .tb_event_o(tb_event_o), .dir_o(dir_o));
`default_nettype wire
